// ---- rtl/lookup_defines.svh ----
// Offsets, field positions, reset values and codes of the address generator
`ifndef LOOKUP_DEFINES_SVH
`define LOOKUP_DEFINES_SVH
// ==========================================================================
// Register byte offsets
`define OFS_QUEUE_BASE   8'h00
`define OFS_DESC_BASE    8'h04
`define OFS_CIRC_BASE    8'h08
`define OFS_PATH_BASE    8'h0C
`define OFS_PATH_FILTER  8'h10
`define OFS_REASM_BASE   8'h14
`define OFS_STATUS       8'h18
// ==========================================================================
// Register indices and reset values
`define IDX_QUEUE_BASE   3'h0
`define IDX_DESC_BASE    3'h1
`define IDX_CIRC_BASE    3'h2
`define IDX_PATH_BASE    3'h3
`define IDX_PATH_FILTER  3'h4
`define IDX_REASM_BASE   3'h5
`define IDX_STATUS       3'h6
`define IDX_NONE         3'h7
`define RST_QUEUE_BASE   16'h0000
`define RST_DESC_BASE    16'h0000
`define RST_CIRC_BASE    16'h0000
`define RST_PATH_BASE    16'h0000
`define RST_PATH_FILTER  16'h0000
`define RST_REASM_BASE   16'h0000
// ==========================================================================
// Field positions and codes
`define FILT_MASK_LSB    8
`define FILT_CMP_LSB     0
`define PTR_DIRECT_BIT   0
`define PTR_SPLIT_LSB    1
`define SPLIT_INVALID    3'h7
`define CIRC_NARROW      3'h7
`define AXI_OKAY         2'h0
`define AXI_SLVERR       2'h2
`endif

// ---- rtl/lookup_pkg.sv ----
// Types shared by the control-memory address generator
`default_nettype none
package lookup_pkg;
  typedef enum logic [1:0] {
    KIND_QUEUE,
    KIND_DESC,
    KIND_CELL,
    KIND_REASM
  } kind_type;

  typedef struct packed {
    kind_type    kind;
    logic [7:0]  vpi;
    logic [15:0] vci;
    logic [9:0]  mid;
    logic [15:0] rptr;
    logic        use_vc;
    logic [7:0]  qptr;
    logic [11:0] desc_num;
    logic [3:0]  word_off;
  } req_type;

  typedef struct packed {
    logic [23:0] addr;
    logic        vc_mode;
    logic        invalid;
  } resp_type;
endpackage
`default_nettype wire

// ---- rtl/vc_addr_calc.sv ----
// Circuit table address from the base register and the received VCI
`timescale 1ns/1ns
`default_nettype none
`include "lookup_defines.svh"
module vc_addr_calc (
  input  wire logic [15:0] base,
  input  wire logic [15:0] vci,
  output logic      [23:0] addr
);
  // ========================================================================
  // Split selection
  wire logic [2:0]  code = base[2:0];
  wire logic [4:0]  nb;
  wire logic [4:0]  nv;
  wire logic [23:0] base_part;
  wire logic [23:0] vci_part;
  // Narrow code keeps 13 base bits but drops one VCI bit
  assign nb = (code == `CIRC_NARROW) ? 5'd13 : 5'd7 + {2'b00, code};
  assign nv = (code == `CIRC_NARROW) ? 5'd9 : 5'd16 - {2'b00, code};
  assign base_part = ({8'h00, base} >> (5'd16 - nb)) << nv;
  assign vci_part  = {8'h00, vci} & ~(24'hFFFFFF << nv);
  assign addr      = base_part | vci_part;
endmodule // vc_addr_calc
`default_nettype wire

// ---- rtl/reasm_ptr_calc.sv ----
// Reassembly table pointer from table pointer, base and MID or VCI
`timescale 1ns/1ns
`default_nettype none
`include "lookup_defines.svh"
module reasm_ptr_calc (
  input  wire logic [15:0] rbase,
  input  wire logic [15:0] ptr,
  input  wire logic [15:0] field,
  output logic      [23:0] addr,
  output logic             invalid
);
  // ========================================================================
  // Direct and split forms
  wire logic [2:0]  code = ptr[`PTR_SPLIT_LSB +: 3];
  wire logic        split = ptr[`PTR_DIRECT_BIT];
  wire logic [4:0]  nf;
  wire logic [15:0] fmask;
  wire logic [15:0] mixed;
  // Pointer MSBs plus field LSBs always total 16 bits
  assign nf    = 5'd10 - {2'b00, code};
  assign fmask = ~(16'hFFFF << nf);
  assign mixed = (ptr & ~fmask) | (field & fmask);
  assign addr  = split ? {1'b0, rbase[15:9], mixed}
                       : {rbase[15:8], ptr};
  assign invalid = split && (code == `SPLIT_INVALID);
endmodule // reasm_ptr_calc
`default_nettype wire

// ---- rtl/reassembly_lookup_addr_gen.sv ----
// Control-memory address generator with its AXI4-Lite register slave
//
// How it works
// - Queue entry address is queue base above the queue pointer.
// - Descriptor address joins base, descriptor number and word offset.
// - Circuit table address joins upper base bits with low VCI bits.
// - Base low code 0..6 selects 7..13 base and 16..10 VCI bits.
// - Base low code 7 uses 13 base and 9 VCI bits.
// - Path table address joins path base with the 8-bit VPI.
// - Filter upper byte is mask, lower byte is compare.
// - XNOR compare with VPI, OR mask; all ones picks circuit table.
// - Pointer bit 0 clear: reassembly base byte joined with pointer.
// - Pointer bit 0 set: 7 base bits, pointer MSBs, field LSBs.
// - Pointer bits 3..1 pick 6..12 pointer bits; code 7 invalid.
// - Field bits come from MID on circuit path, else VCI.
// - Direct form reaches 256 path and 65536 circuit entries.
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "lookup_defines.svh"
module reassembly_lookup_addr_gen (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [7:0]           awaddr,
  input  wire logic                 wvalid,
  output logic                      wready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  output logic                      bvalid,
  input  wire logic                 bready,
  output logic [1:0]                bresp,
  input  wire logic                 arvalid,
  output logic                      arready,
  input  wire logic [7:0]           araddr,
  output logic                      rvalid,
  input  wire logic                 rready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire lookup_pkg::req_type  req,
  output logic                      resp_valid,
  output lookup_pkg::resp_type      resp,
  output logic                      mem_valid
);
  // ========================================================================
  // Helpers
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    logic [2:0] r;
    r = `IDX_NONE;
    unique case (a)
      `OFS_QUEUE_BASE:  r = `IDX_QUEUE_BASE;
      `OFS_DESC_BASE:   r = `IDX_DESC_BASE;
      `OFS_CIRC_BASE:   r = `IDX_CIRC_BASE;
      `OFS_PATH_BASE:   r = `IDX_PATH_BASE;
      `OFS_PATH_FILTER: r = `IDX_PATH_FILTER;
      `OFS_REASM_BASE:  r = `IDX_REASM_BASE;
      `OFS_STATUS:      r = `IDX_STATUS;
      default:          r = `IDX_NONE;
    endcase
    return r;
  endfunction

  // All ones after XNOR-then-OR means the cell goes the circuit way
  function automatic logic filter_hit(input logic [15:0] f,
                                      input logic [7:0]  vpi);
    logic [7:0] m;
    logic [7:0] c;
    m = f[`FILT_MASK_LSB +: 8];
    c = f[`FILT_CMP_LSB +: 8];
    return &(~(c ^ vpi) | m);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // ========================================================================
  // Register file
  logic [15:0] cfg_q [0:5];
  logic        aw_have_q;
  logic [7:0]  aw_addr_q;
  logic        w_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [7:0]  inval_cnt_q;
  logic        last_vc_q;
  logic        last_inval_q;

  wire logic [15:0] queue_base_address    = cfg_q[`IDX_QUEUE_BASE];
  wire logic [15:0] descriptor_table_base = cfg_q[`IDX_DESC_BASE];
  wire logic [15:0] circuit_table_base    = cfg_q[`IDX_CIRC_BASE];
  wire logic [15:0] path_table_base       = cfg_q[`IDX_PATH_BASE];
  wire logic [15:0] path_filter           = cfg_q[`IDX_PATH_FILTER];
  wire logic [15:0] reassembly_table_base = cfg_q[`IDX_REASM_BASE];
  wire logic [15:0] status_word = {inval_cnt_q, 6'h00,
                                   last_inval_q, last_vc_q};

  wire logic        do_wr  = aw_have_q && w_have_q && !bvalid_q;
  wire logic [2:0]  wr_idx = reg_index(aw_addr_q);
  wire logic [2:0]  rd_idx = reg_index(araddr);
  wire logic        ar_hs  = arvalid && arready;
  wire logic [15:0] rd_word;

  // Readies drop with ce so no handshake is taken while frozen
  assign awready = ce && !aw_have_q && !bvalid_q;
  assign wready  = ce && !w_have_q && !bvalid_q;
  assign arready = ce && !rvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign rd_word = (rd_idx < `IDX_STATUS) ? cfg_q[rd_idx]
                 : (rd_idx == `IDX_STATUS) ? status_word : 16'h0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (do_wr) begin
        aw_have_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (do_wr) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `AXI_OKAY;
    end else if (ce) begin
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_idx == `IDX_NONE) ? `AXI_SLVERR : `AXI_OKAY;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q[`IDX_QUEUE_BASE]  <= `RST_QUEUE_BASE;
      cfg_q[`IDX_DESC_BASE]   <= `RST_DESC_BASE;
      cfg_q[`IDX_CIRC_BASE]   <= `RST_CIRC_BASE;
      cfg_q[`IDX_PATH_BASE]   <= `RST_PATH_BASE;
      cfg_q[`IDX_PATH_FILTER] <= `RST_PATH_FILTER;
      cfg_q[`IDX_REASM_BASE]  <= `RST_REASM_BASE;
    end else if (ce && do_wr && wr_idx < `IDX_STATUS) begin
      cfg_q[wr_idx] <= merge(cfg_q[wr_idx], w_data_q, w_strb_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `AXI_OKAY;
    end else if (ce) begin
      if (ar_hs) begin
        rvalid_q <= 1'b1;
        rdata_q  <= {16'h0000, rd_word};
        rresp_q  <= (rd_idx == `IDX_NONE) ? `AXI_SLVERR : `AXI_OKAY;
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Address generation
  lookup_pkg::resp_type resp_d;
  lookup_pkg::resp_type resp_q;
  logic                 resp_valid_q;
  wire logic [23:0] circ_addr;
  wire logic [23:0] reasm_addr;
  wire logic        reasm_bad;
  wire logic        acc    = req_valid && ce;
  wire logic        vc_hit = filter_hit(path_filter, req.vpi);
  wire logic [15:0] field  = req.use_vc ? {6'h00, req.mid} : req.vci;

  vc_addr_calc u_circ (
    .base (circuit_table_base),
    .vci  (req.vci),
    .addr (circ_addr)
  );

  reasm_ptr_calc u_reasm (
    .rbase   (reassembly_table_base),
    .ptr     (req.rptr),
    .field   (field),
    .addr    (reasm_addr),
    .invalid (reasm_bad)
  );

  assign req_ready = ce;

  always_comb begin
    resp_d = '0;
    unique case (req.kind)
      lookup_pkg::KIND_QUEUE: begin
        resp_d.addr = {queue_base_address, req.qptr};
      end
      lookup_pkg::KIND_DESC: begin
        resp_d.addr = {descriptor_table_base[15:8], req.desc_num,
                       req.word_off};
      end
      lookup_pkg::KIND_CELL: begin
        resp_d.vc_mode = vc_hit;
        resp_d.addr = vc_hit ? circ_addr
                             : {path_table_base, req.vpi};
      end
      lookup_pkg::KIND_REASM: begin
        resp_d.invalid = reasm_bad;
        resp_d.addr = reasm_bad ? 24'h000000 : reasm_addr;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_valid_q <= 1'b0;
      resp_q       <= '0;
    end else if (ce) begin
      resp_valid_q <= req_valid;
      if (req_valid) begin
        resp_q <= resp_d;
      end
    end
  end

  // Status keeps the last decision and a saturating count of bad splits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inval_cnt_q  <= 8'h00;
      last_vc_q    <= 1'b0;
      last_inval_q <= 1'b0;
    end else if (acc) begin
      if (req.kind == lookup_pkg::KIND_CELL) begin
        last_vc_q <= vc_hit;
      end
      if (req.kind == lookup_pkg::KIND_REASM) begin
        last_inval_q <= reasm_bad;
        if (reasm_bad && inval_cnt_q != 8'hFF) begin
          inval_cnt_q <= inval_cnt_q + 8'h01;
        end
      end
    end
  end

  assign resp_valid = resp_valid_q;
  assign resp       = resp_q;
  assign mem_valid  = resp_valid_q && !resp_q.invalid;

  // ========================================================================
  // Checks
  wire logic [1:0]  k_kind = req.kind;
  wire logic [7:0]  k_qptr = req.qptr;
  wire logic [11:0] k_desc = req.desc_num;
  wire logic [3:0]  k_off  = req.word_off;
  wire logic [7:0]  k_vpi  = req.vpi;
  wire logic [15:0] k_vci  = req.vci;
  wire logic [9:0]  k_mid  = req.mid;
  wire logic [15:0] k_rptr = req.rptr;
  wire logic        k_usev = req.use_vc;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_queue_addr;
    acc && k_kind == 2'h0 |=> resp_valid &&
      resp.addr == {$past(queue_base_address), $past(k_qptr)};
  endproperty
  a_queue_addr: assert property (p_queue_addr)
    else $error("queue entry address wrong");

  property p_desc_addr;
    acc && k_kind == 2'h1 |=> resp.addr[3:0] == $past(k_off) &&
      resp.addr[15:4] == $past(k_desc) &&
      resp.addr[23:16] == $past(descriptor_table_base[15:8]);
  endproperty
  a_desc_addr: assert property (p_desc_addr)
    else $error("descriptor address wrong");

  property p_circ_wide;
    acc && k_kind == 2'h2 && vc_hit && circuit_table_base[2:0] == 3'h0
      |=> resp.addr == {1'b0, $past(circuit_table_base[15:9]),
                        $past(k_vci)};
  endproperty
  a_circ_wide: assert property (p_circ_wide)
    else $error("circuit address with code 0 wrong");

  property p_circ_narrow;
    acc && k_kind == 2'h2 && vc_hit && circuit_table_base[2:0] == 3'h7
      |=> resp.addr == {2'b00, $past(circuit_table_base[15:3]),
                        $past(k_vci[8:0])};
  endproperty
  a_circ_narrow: assert property (p_circ_narrow)
    else $error("circuit address with code 7 wrong");

  property p_path_addr;
    acc && k_kind == 2'h2 && !vc_hit
      |=> !resp.vc_mode && resp.addr == {$past(path_table_base),
                                         $past(k_vpi)};
  endproperty
  a_path_addr: assert property (p_path_addr)
    else $error("path table address wrong");

  property p_filter;
    acc && k_kind == 2'h2 |=> resp.vc_mode ==
      &(~($past(path_filter[7:0]) ^ $past(k_vpi)) |
        $past(path_filter[15:8]));
  endproperty
  a_filter: assert property (p_filter)
    else $error("filter decision wrong");

  property p_direct;
    acc && k_kind == 2'h3 && !k_rptr[0] |=> mem_valid &&
      resp.addr == {$past(reassembly_table_base[15:8]), $past(k_rptr)};
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct reassembly pointer wrong");

  property p_split_mid;
    acc && k_kind == 2'h3 && k_rptr[3:0] == 4'h1 && k_usev
      |=> resp.addr == {1'b0, $past(reassembly_table_base[15:9]),
                        $past(k_rptr[15:10]), $past(k_mid)};
  endproperty
  a_split_mid: assert property (p_split_mid)
    else $error("split pointer with MID wrong");

  property p_split_vci;
    acc && k_kind == 2'h3 && k_rptr[3:0] == 4'hD && !k_usev
      |=> resp.addr[15:0] == {$past(k_rptr[15:4]), $past(k_vci[3:0])};
  endproperty
  a_split_vci: assert property (p_split_vci)
    else $error("split pointer with VCI wrong");

  property p_invalid;
    acc && k_kind == 2'h3 && k_rptr[3:0] == 4'hF
      |=> resp_valid && resp.invalid && !mem_valid;
  endproperty
  a_invalid: assert property (p_invalid)
    else $error("invalid split still issued an access");
endmodule // reassembly_lookup_addr_gen
`default_nettype wire

// ---- sim/ctrl_mem_model.sv ----
// Control memory model that counts the accesses it is offered
`timescale 1ns/1ns
`default_nettype none
module ctrl_mem_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        mem_valid,
  input  wire logic [23:0] addr,
  output logic      [31:0] n_acc
);
  // Table contents are not kept; only the access stream is judged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_acc <= 32'h0000_0000;
    end else if (mem_valid && addr[23:0] !== 24'hXXXXXX) begin
      n_acc <= n_acc + 32'h0000_0001;
    end
  end
endmodule // ctrl_mem_model
`default_nettype wire

// ---- sim/tb.sv ----
// Testbench for the control-memory address generator
`timescale 1ns/1ns
`default_nettype none
`include "lookup_defines.svh"
module tb;
  // ==========
  // Signals
  logic                 aclk, aresetn, ce, awvalid, awready, wvalid, wready;
  logic                 bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]           awaddr, araddr;
  logic [31:0]          wdata, rdata, n_acc, rv;
  logic [3:0]           wstrb;
  logic [1:0]           bresp, rresp, r;
  logic                 req_valid, req_ready, resp_valid, mem_valid;
  logic                 last_vcm, last_inv;
  lookup_pkg::req_type  req;
  lookup_pkg::resp_type resp;
  logic [15:0]          m [0:5];
  logic [15:0]          filt [0:2] = '{16'h0F3A, 16'hFF00, 16'h00A5};
  int                   n_fail, checks_done, n_mem, n_inv;
  lookup_pkg::req_type  q[$];

  reassembly_lookup_addr_gen DUT (
    .aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .req_valid, .req_ready, .req,
    .resp_valid, .resp, .mem_valid
  );
  ctrl_mem_model mem (.aclk, .aresetn, .mem_valid, .addr(resp.addr), .n_acc);

  always #10 aclk = ~aclk;

  // ==========
  // Checking and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Handshakes are judged on the settled values just before each edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] rs);
    logic aw_hs, w_hs, b_hs;
    b_hs = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid && bready;
      rs = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] rs);
    logic ar_hs, r_hs;
    r_hs = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs = rvalid && rready;
      d = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d, r);
    check(d, e);
    check({30'h0, r}, {30'h0, `AXI_OKAY});
  endtask

  task automatic wreg(input int i, input logic [15:0] v);
    wr(8'(i * 4), {16'hFFFF, v}, 4'hF, r);
    m[i] = v;
    check({30'h0, r}, {30'h0, `AXI_OKAY});
  endtask

  // ==========
  // Expected addresses
  function automatic logic [23:0] circ(input logic [15:0] b,
                                       input logic [15:0] v);
    int nb, nv;
    logic [31:0] a;
    nb = (b[2:0] == `CIRC_NARROW) ? 13 : 7 + int'(b[2:0]);
    nv = (b[2:0] == `CIRC_NARROW) ? 9 : 16 - int'(b[2:0]);
    a = ({16'h0000, b} >> (16 - nb)) << nv;
    a = a | ({16'h0000, v} & ((32'h1 << nv) - 32'h1));
    return a[23:0];
  endfunction

  function automatic logic [23:0] ra(input lookup_pkg::req_type p);
    logic [15:0] f, k;
    f = p.use_vc ? {6'h00, p.mid} : p.vci;
    k = 16'hFFFF << (10 - int'(p.rptr[3:1]));
    if (!p.rptr[0]) return {m[5][15:8], p.rptr};
    if (p.rptr[3:1] == `SPLIT_INVALID) return 24'h000000;
    return {1'b0, m[5][15:9], (p.rptr & k) | (f & ~k)};
  endfunction

  function automatic lookup_pkg::req_type mk(input lookup_pkg::kind_type k,
                                             input logic [15:0] x,
                                             input logic [15:0] y);
    mk = '{kind: k, vpi: x[7:0], vci: y, mid: y[9:0], rptr: x,
           use_vc: y[15], qptr: x[7:0], desc_num: x[11:0],
           word_off: y[3:0]};
  endfunction

  task automatic chk_resp(input lookup_pkg::req_type p);
    logic vcm, inv;
    logic [23:0] e;
    vcm = &((~(m[4][7:0] ^ p.vpi)) | m[4][15:8]);
    inv = p.kind == lookup_pkg::KIND_REASM && p.rptr[0] && p.rptr[3:1] == 7;
    check({29'h0, resp_valid, mem_valid, resp.invalid},
          {29'h0, 1'b1, !inv, inv});
    n_mem += int'(!inv);
    case (p.kind)
      lookup_pkg::KIND_QUEUE: begin
        check({8'h00, resp.addr}, {8'h00, m[0], p.qptr});
      end
      lookup_pkg::KIND_DESC: begin
        e = {m[1][15:8], p.desc_num, p.word_off};
        check({8'h00, resp.addr}, {8'h00, e});
      end
      lookup_pkg::KIND_CELL: begin
        e = vcm ? circ(m[2], p.vci) : {m[3], p.vpi};
        check({31'h0, resp.vc_mode}, {31'h0, vcm});
        check({8'h00, resp.addr}, {8'h00, e});
        last_vcm = vcm;
      end
      default: begin
        check({8'h00, resp.addr}, {8'h00, ra(p)});
        last_inv = inv;
        n_inv += int'(inv);
      end
    endcase
  endtask

  // Requests go back to back; each answer is judged one edge later
  // Ends just after a rising edge so the next bus task starts in step
  task automatic run(input lookup_pkg::req_type s[$]);
    for (int i = 0; i <= s.size(); i++) begin
      @(posedge aclk);
      req_valid <= (i < s.size());
      if (i < s.size()) req <= s[i];
      @(negedge aclk);
      if (i > 0) chk_resp(s[i-1]);
    end
    @(posedge aclk);
  endtask

  // ==========
  // Main sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, req_valid} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    req = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 7; i++) rchk(8'(i * 4), 32'h0);
    for (int i = 0; i < 6; i++) begin
      wreg(i, 16'hC3A5 ^ 16'(i << 9));
      rchk(8'(i * 4), {16'h0000, m[i]});
    end
    wr(`OFS_QUEUE_BASE, 32'h0000_7E00, 4'h2, r);
    m[0][15:8] = 8'h7E;
    rchk(`OFS_QUEUE_BASE, {16'h0000, m[0]});
    wr(8'h1C, 32'h0000_0001, 4'hF, r);
    check({30'h0, r}, {30'h0, `AXI_SLVERR});
    rd(8'h1C, rv, r);
    check({30'h0, r}, {30'h0, `AXI_SLVERR});
    wr(`OFS_STATUS, 32'hFFFF_FFFF, 4'hF, r);
    rchk(`OFS_STATUS, 32'h0);
    wreg(0, 16'hABCD);
    wreg(1, 16'h9E5F);
    wreg(3, 16'h1357);
    wreg(5, 16'hB6FF);
    run({mk(lookup_pkg::KIND_QUEUE, 16'h00FF, 16'h0),
         mk(lookup_pkg::KIND_DESC, 16'h0FFF, 16'h000F),
         mk(lookup_pkg::KIND_DESC, 16'h0001, 16'h0002)});
    for (int c = 0; c < 8; c++) begin
      wreg(2, 16'hD6B0 | 16'(c));
      wreg(4, filt[c % 3]);
      run({mk(lookup_pkg::KIND_CELL, 16'h003B, 16'hFFFF),
           mk(lookup_pkg::KIND_CELL, 16'h00A5, 16'h8421),
           mk(lookup_pkg::KIND_CELL, 16'h003A, 16'h7FFF)});
    end
    q = {};
    for (int c = 0; c < 16; c++) begin
      q.push_back(mk(lookup_pkg::KIND_REASM, 16'hC5A1 | 16'((c % 8) << 1),
                     c < 8 ? 16'h93FF : 16'h1AAB));
    end
    q.push_back(mk(lookup_pkg::KIND_REASM, 16'hFFFE, 16'h0));
    q.push_back(mk(lookup_pkg::KIND_REASM, 16'h7FFE, 16'h8000));
    run(q);
    rchk(`OFS_STATUS, {16'h0, 8'(n_inv), 6'h00, last_inv, last_vcm});
    @(posedge aclk);
    ce <= 1'b0;
    req <= mk(lookup_pkg::KIND_QUEUE, 16'h0011, 16'h0);
    req_valid <= 1'b1;
    @(negedge aclk);
    check({31'h0, req_ready}, 32'h0);
    @(posedge aclk);
    req_valid <= 1'b0;
    ce <= 1'b1;
    @(negedge aclk);
    check({31'h0, resp_valid}, 32'h0);
    check(n_acc, 32'(n_mem));
    end_of_test();
  end

  initial begin
    repeat (6000) @(posedge aclk);
    n_fail++;
    end_of_test();
  end
endmodule // tb
`default_nettype wire
